/* File: verilog/pcg_pkg.sv */
// constants for the peripheral clock gate and reset control block
`default_nettype none

package pcg_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] PCG_ADDR_GATE    = 32'hE01FC0C4;
    localparam logic [31:0] PCG_ADDR_DIV     = 32'hE01FC100;
    localparam logic [31:0] PCG_ADDR_CAUSE   = 32'hE01FC180;

    // ------------------------------------------------------------------
    // gate register fields
    // ------------------------------------------------------------------
    localparam int          PCG_BIT_TIMER0   = 1;
    localparam int          PCG_BIT_TIMER1   = 2;
    localparam int          PCG_BIT_SERIAL0  = 3;
    localparam int          PCG_BIT_SERIAL1  = 4;
    localparam int          PCG_BIT_TWOWIRE0 = 7;
    localparam int          PCG_BIT_SYNCSER  = 8;
    localparam int          PCG_BIT_CALENDAR = 9;
    localparam int          PCG_BIT_SSPORT   = 10;
    localparam int          PCG_BIT_CONVERT  = 12;
    localparam int          PCG_BIT_TWOWIRE1 = 19;
    localparam int          PCG_BIT_TIMER2   = 22;
    localparam int          PCG_BIT_TIMER3   = 23;
    localparam logic [31:0] PCG_GATE_USED    = 32'h00C8179E;
    localparam logic [31:0] PCG_GATE_RESET   = 32'h00C8179E;

    // ------------------------------------------------------------------
    // reset cause fields
    // ------------------------------------------------------------------
    localparam int          PCG_CAUSE_W      = 3;
    localparam int          PCG_CAUSE_POR    = 0;
    localparam int          PCG_CAUSE_PIN    = 1;
    localparam int          PCG_CAUSE_WDOG   = 2;
    localparam logic [2:0]  PCG_CAUSE_RESET  = 3'h1;

    // ------------------------------------------------------------------
    // peripheral clock divider select codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  PCG_DIV_QUARTER  = 2'h0;
    localparam logic [1:0]  PCG_DIV_FULL     = 2'h1;
    localparam logic [1:0]  PCG_DIV_HALF     = 2'h2;
    localparam logic [1:0]  PCG_DIV_RSVD     = 2'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          PCG_CLK_PERIOD_NS = 4;
    localparam int          PCG_GLITCH_NS     = 100;
    localparam int          PCG_GLITCH_CYC    =
        (PCG_GLITCH_NS + PCG_CLK_PERIOD_NS - 1) / PCG_CLK_PERIOD_NS;
    localparam int          PCG_WAKE_CLOCKS   = 4096;
    localparam int          PCG_INIT_CYC      = 16;
    localparam int          PCG_CNT_W         = 13;
    localparam logic [31:0] PCG_BOOT_ADDR     = 32'h00000000;
    localparam int          PCG_STRAP_W       = 4;

    // ------------------------------------------------------------------
    // reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PCG_ST_HOLD,
        PCG_ST_WAIT_OSC,
        PCG_ST_COUNT,
        PCG_ST_INIT,
        PCG_ST_FLASH,
        PCG_ST_RUN
    } pcg_state_type;

endpackage

`default_nettype wire

/* File: verilog/pcg_sys_ctrl.sv */
// peripheral clock gating, reset sequencing, cause flags, bus clock divider
//
// Implementation choice: the strobed register port.
`default_nettype none

// Function
// [R1] enable bit one passes clock, zero gates
// [R2] watchdog, GPIO, pinmux, sysctrl never gated
// [R3] peripheral access valid only when enabled
// [R4] bits 1-4: timers 0,1, serial 0,1
// [R5] bits 7-10: twowire0, SPI, calendar, SSP
// [R6] bits 12,19,22,23: converter, twowire1, timers
// [R7] every reset enables all gated peripherals
// [R8] software writes zero to reserved bits
// [R9] converter power-down cleared before clock off
// [R10] power-aware software clears unused enables
// [R11] pin/watchdog reset runs full wake sequence
// [R12] glitch filter on external reset pin
// [R13] pin held 10 ms, later 300 ns
// [R14] power-on reset registered within two clocks
// [R15] processor starts at address zero
// [R16] straps latched only on external reset
// [R17] flash operation aborted, reset waits settling
// [R18] write one clears cause flag
// [R19] power-on sets bit 0, clears others
// [R20] pin reset sets bit 1
// [R21] watchdog reset sets bit 2, others clear
// [R22] bus clock full/half/quarter, quarter default
// [R23] pll kept running through idle
// [R24] wake timer counts 4096 clocks
// [R25] divider code 11 ignored
// [R26] gated peripheral access ignored, no stall

module pcg_sys_ctrl
    import pcg_pkg::*;
#(
    parameter int WAKE_CLOCKS = PCG_WAKE_CLOCKS
) (
    // clock and power-on reset
    input  wire logic                    clock_in,
    input  wire logic                    rst_n_in,
    // reset sources and oscillator
    input  wire logic                    ext_reset_n_in,
    input  wire logic                    watchdog_timeout_in,
    input  wire logic                    watchdog_reset_enable_in,
    input  wire logic                    osc_running_in,
    // flash status
    input  wire logic                    flash_busy_in,
    input  wire logic                    flash_hv_settled_in,
    // configuration straps and power state
    input  wire logic [PCG_STRAP_W-1:0]  config_pins_in,
    input  wire logic                    idle_mode_in,
    input  wire logic                    pll_running_in,
    // peripheral access check
    input  wire logic                    periph_access_in,
    input  wire logic [4:0]              periph_sel_in,
    // register port
    input  wire logic [31:0]             reg_addr_in,
    input  wire logic [31:0]             reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic      [31:0]             reg_rdata_out,
    // clock enables
    output logic      [31:0]             periph_clock_enable_out,
    output logic                         always_on_enable_out,
    output logic                         periph_clock_tick_out,
    output logic                         pll_keep_running_out,
    // reset outputs
    output logic                         chip_reset_n_out,
    output logic      [31:0]             boot_address_out,
    output logic      [PCG_STRAP_W-1:0]  config_latch_out,
    output logic                         flash_abort_out,
    // access result
    output logic                         periph_access_valid_out,
    output logic                         periph_access_refused_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic gate_on(input logic [31:0] gate,
                                     input logic [4:0]  sel);
        gate_on = gate[sel] & PCG_GATE_USED[sel];
    endfunction

    function automatic logic [1:0] div_limit(input logic [1:0] sel);
        unique case (sel)
            PCG_DIV_FULL: div_limit = 2'h0;
            PCG_DIV_HALF: div_limit = 2'h1;
            default:      div_limit = 2'h3;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------------
    logic                    rst_meta_r;
    logic                    rst_sync_n_r;
    logic                    por_first_r;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1; // see [R14]
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // external reset glitch filter
    // ------------------------------------------------------------------
    logic [5:0]              ext_low_cnt_r;
    logic                    ext_filt_r;

    // short pulses never reach the counter limit, so they are dropped
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ext_low_cnt_r <= 6'h00;
            ext_filt_r    <= 1'b0;
        end else if (ext_reset_n_in) begin
            ext_low_cnt_r <= 6'h00;
            ext_filt_r    <= 1'b0;
        end else if (!ext_filt_r) begin
            if (ext_low_cnt_r == 6'(PCG_GLITCH_CYC - 1)) begin
                ext_filt_r <= 1'b1; // see [R12]
            end else begin
                ext_low_cnt_r <= ext_low_cnt_r + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    pcg_state_type           state_r;
    pcg_state_type           state_nxt;
    logic [PCG_CNT_W-1:0]    wait_cnt_r;
    logic                    wdog_evt;
    logic                    reset_start;
    logic                    flash_hold_r;

    assign wdog_evt    = watchdog_timeout_in & watchdog_reset_enable_in
                         & (state_r == PCG_ST_RUN);
    assign reset_start = (ext_filt_r | wdog_evt) & (state_r == PCG_ST_RUN);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PCG_ST_HOLD: begin
                if (!ext_filt_r) state_nxt = PCG_ST_WAIT_OSC;
            end
            PCG_ST_WAIT_OSC: begin
                if (osc_running_in) state_nxt = PCG_ST_COUNT;
            end
            PCG_ST_COUNT: begin
                if (wait_cnt_r == PCG_CNT_W'(WAKE_CLOCKS - 1)) begin
                    state_nxt = PCG_ST_INIT; // see [R24]
                end
            end
            PCG_ST_INIT: begin
                if (wait_cnt_r == PCG_CNT_W'(PCG_INIT_CYC - 1)) begin
                    state_nxt = PCG_ST_FLASH;
                end
            end
            PCG_ST_FLASH: begin
                // after an aborted flash operation, completion held off until flash voltages settle
                if (!flash_hold_r || flash_hv_settled_in) begin
                    state_nxt = PCG_ST_RUN; // see [R17]
                end
            end
            PCG_ST_RUN: begin
                if (reset_start) state_nxt = PCG_ST_HOLD; // see [R11]
            end
        endcase
        // the pin wins over any stage of the sequence
        if (ext_filt_r) state_nxt = PCG_ST_HOLD; // see [R11]
    end

    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            state_r          <= PCG_ST_HOLD;
            wait_cnt_r       <= '0;
            chip_reset_n_out <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            chip_reset_n_out <= (state_nxt == PCG_ST_RUN); // see [R11]
            if (state_nxt != state_r) begin
                wait_cnt_r <= '0;
            end else begin
                wait_cnt_r <= wait_cnt_r + PCG_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            flash_hold_r    <= 1'b0;
            flash_abort_out <= 1'b0;
        end else begin
            flash_abort_out <= reset_start & flash_busy_in; // see [R17]
            if (reset_start && flash_busy_in) begin
                flash_hold_r <= 1'b1;
            end else if (state_r == PCG_ST_RUN) begin
                flash_hold_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // boot address and configuration straps
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            por_first_r      <= 1'b1;
            config_latch_out <= '0;
            boot_address_out <= PCG_BOOT_ADDR;
        end else begin
            por_first_r      <= 1'b0;
            boot_address_out <= PCG_BOOT_ADDR; // see [R15]
            // watchdog resets leave the straps as they were
            if (ext_filt_r || por_first_r) begin
                config_latch_out <= config_pins_in; // see [R16]
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    logic [31:0]             gate_r;
    logic [1:0]              div_r;
    logic [2:0]              cause_r;
    logic [2:0]              cause_set;
    logic [2:0]              cause_clr;
    logic                    wr_gate;
    logic                    wr_div;
    logic                    wr_cause;

    assign wr_gate  = reg_wr_in & (reg_addr_in == PCG_ADDR_GATE);
    assign wr_div   = reg_wr_in & (reg_addr_in == PCG_ADDR_DIV);
    assign wr_cause = reg_wr_in & (reg_addr_in == PCG_ADDR_CAUSE);

    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            gate_r <= PCG_GATE_RESET;
        end else if (state_r != PCG_ST_RUN) begin
            gate_r <= PCG_GATE_RESET; // see [R7]
        end else if (wr_gate) begin
            // reserved positions are not stored
            gate_r <= reg_wdata_in & PCG_GATE_USED; // see [R1] [R8]
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            div_r <= PCG_DIV_QUARTER;
        end else if (state_r != PCG_ST_RUN) begin
            div_r <= PCG_DIV_QUARTER; // see [R22]
        end else if (wr_div && reg_wdata_in[1:0] != PCG_DIV_RSVD) begin
            div_r <= reg_wdata_in[1:0]; // see [R25]
        end
    end

    always_comb begin
        cause_set = 3'h0;
        cause_clr = 3'h0;
        cause_set[PCG_CAUSE_PIN]  = ext_filt_r; // see [R20]
        cause_set[PCG_CAUSE_WDOG] = wdog_evt;   // see [R21]
        cause_clr[PCG_CAUSE_WDOG] = ext_filt_r; // see [R21]
        if (wr_cause) begin
            cause_clr = cause_clr | reg_wdata_in[2:0]; // see [R18]
        end
    end

    // power-on sets the reset value; a new event beats a clear
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cause_r <= PCG_CAUSE_RESET; // see [R19]
        end else begin
            cause_r <= (cause_r & ~cause_clr) | cause_set; // see [R19]
        end
    end

    // ------------------------------------------------------------------
    // register reads: data only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                PCG_ADDR_GATE:  reg_rdata_out <= gate_r;
                PCG_ADDR_DIV:   reg_rdata_out <= {30'h0, div_r};
                PCG_ADDR_CAUSE: reg_rdata_out <= {29'h0, cause_r};
                default:        reg_rdata_out <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // clock enables
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            periph_clock_enable_out <= PCG_GATE_RESET;
            always_on_enable_out    <= 1'b1;
        end else begin
            periph_clock_enable_out <= gate_r; // see [R1] [R4] [R5] [R6]
            always_on_enable_out    <= 1'b1;   // see [R2]
        end
    end

    // ------------------------------------------------------------------
    // bus clock divider
    // ------------------------------------------------------------------
    logic [1:0]              pclk_cnt_r;

    // >= lets a smaller limit take over at once: one period may be short
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            pclk_cnt_r            <= 2'h0;
            periph_clock_tick_out <= 1'b0;
        end else if (pclk_cnt_r >= div_limit(div_r)) begin
            pclk_cnt_r            <= 2'h0;
            periph_clock_tick_out <= 1'b1; // see [R22]
        end else begin
            pclk_cnt_r            <= pclk_cnt_r + 2'h1;
            periph_clock_tick_out <= 1'b0;
        end
    end

    // pll state frozen during idle so the divider keeps its source
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            pll_keep_running_out <= 1'b0;
        end else if (!idle_mode_in) begin
            pll_keep_running_out <= pll_running_in; // see [R23]
        end
    end

    // ------------------------------------------------------------------
    // peripheral access check
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            periph_access_valid_out   <= 1'b0;
            periph_access_refused_out <= 1'b0;
        end else begin
            periph_access_valid_out   <= periph_access_in
                                         & gate_on(gate_r, periph_sel_in);
            periph_access_refused_out <= periph_access_in
                                         & ~gate_on(gate_r, periph_sel_in);
        end                                           // see [R3] [R26]
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_sync_n_r);

    property p_gate_write;
        (wr_gate && state_r == PCG_ST_RUN) |=>
            gate_r == ($past(reg_wdata_in) & PCG_GATE_USED) ##1
            periph_clock_enable_out == $past(gate_r);
    endproperty
    a_gate_write: assert property (p_gate_write) // see [R1]
        else $error("gate register write not applied");

    property p_gate_reset;
        (state_r != PCG_ST_RUN) |=> gate_r == PCG_GATE_RESET
                                    && div_r == PCG_DIV_QUARTER;
    endproperty
    a_gate_reset: assert property (p_gate_reset) // see [R7]
        else $error("reset did not restore enables or divider");

    property p_access;
        periph_access_in |=> periph_access_valid_out ==
            $past(gate_on(gate_r, periph_sel_in))
            && periph_access_refused_out != periph_access_valid_out;
    endproperty
    a_access: assert property (p_access) // see [R26]
        else $error("peripheral access check wrong");

    property p_div_rsvd;
        (wr_div && reg_wdata_in[1:0] == PCG_DIV_RSVD
         && state_r == PCG_ST_RUN) |=> $stable(div_r);
    endproperty
    a_div_rsvd: assert property (p_div_rsvd) // see [R25]
        else $error("reserved divider code changed setting");

    property p_tick_quarter;
        (periph_clock_tick_out && div_r == PCG_DIV_QUARTER && !wr_div)
            |=> !periph_clock_tick_out;
    endproperty
    a_tick_quarter: assert property (p_tick_quarter) // see [R22]
        else $error("quarter rate tick too close");

    property p_cause_clear;
        (wr_cause && reg_wdata_in[PCG_CAUSE_POR] && state_r == PCG_ST_RUN)
            |=> !cause_r[PCG_CAUSE_POR];
    endproperty
    a_cause_clear: assert property (p_cause_clear) // see [R18]
        else $error("write one did not clear flag");

    property p_wdog_flag;
        wdog_evt |=> cause_r[PCG_CAUSE_WDOG] ##1 !chip_reset_n_out;
    endproperty
    a_wdog_flag: assert property (p_wdog_flag) // see [R21]
        else $error("watchdog reset not recorded");

    property p_wake_count;
        (state_r == PCG_ST_INIT && $past(state_r) != PCG_ST_INIT) |->
            $past(state_r) == PCG_ST_COUNT
            && $past(wait_cnt_r) == PCG_CNT_W'(WAKE_CLOCKS - 1);
    endproperty
    a_wake_count: assert property (p_wake_count) // see [R24]
        else $error("wake timer ended early");

    property p_release;
        $rose(chip_reset_n_out) |-> $past(state_r) == PCG_ST_FLASH
                                    && !ext_filt_r;
    endproperty
    a_release: assert property (p_release) // see [R11]
        else $error("internal reset released out of sequence");

    property p_glitch;
        $rose(ext_filt_r) |->
            $past(ext_low_cnt_r) == 6'(PCG_GLITCH_CYC - 1);
    endproperty
    a_glitch: assert property (p_glitch) // see [R12]
        else $error("glitch filter accepted short pulse");

    property p_strap_hold;
        (!ext_filt_r && !por_first_r) |=> $stable(config_latch_out);
    endproperty
    a_strap_hold: assert property (p_strap_hold) // see [R16]
        else $error("straps changed without external reset");

    c_wdog: cover property (wdog_evt ##[1:20] !chip_reset_n_out);
    c_release: cover property ($rose(chip_reset_n_out));
    c_refused: cover property (periph_access_refused_out);
    c_half: cover property (div_r == PCG_DIV_HALF && periph_clock_tick_out);

endmodule

`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the clock gate and reset control block
`default_nettype none
module tb
    import pcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WK = 8;
    logic        clk = 0, rst_n = 0, pin_n = 1, wdt = 0, wden = 1, osc = 1;
    logic        acc = 0, wr = 0, rd = 0, aon, tick, crst_n, av, ar;
    logic        fbusy = 0, fset = 1, idle = 0, pll = 1, fab, pkr;
    logic        fab_seen = 0;
    logic [3:0]  cfgp = 4'hA, cfg;
    logic [4:0]  sel = 0;
    logic [31:0] addr = 0, wd = 0, rdata, pce, boot, v;
    int          failures = 0, n_compared = 0, n;
    int          bits[12] = '{1, 2, 3, 4, 7, 8, 9, 10, 12, 19, 22, 23};
    // ------------------------------------------------------------------
    // device and clock
    // ------------------------------------------------------------------
    pcg_sys_ctrl #(.WAKE_CLOCKS(WK)) DUT (
        .clock_in(clk), .rst_n_in(rst_n), .ext_reset_n_in(pin_n),
        .watchdog_timeout_in(wdt), .watchdog_reset_enable_in(wden),
        .osc_running_in(osc), .flash_busy_in(fbusy),
        .flash_hv_settled_in(fset), .config_pins_in(cfgp),
        .idle_mode_in(idle), .pll_running_in(pll),
        .periph_access_in(acc), .periph_sel_in(sel), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .periph_clock_enable_out(pce),
        .always_on_enable_out(aon), .periph_clock_tick_out(tick),
        .pll_keep_running_out(pkr), .chip_reset_n_out(crst_n),
        .boot_address_out(boot), .config_latch_out(cfg),
        .flash_abort_out(fab), .periph_access_valid_out(av),
        .periph_access_refused_out(ar));
    initial begin
        forever #2 clk = ~clk;
    end
    // the abort is a one-cycle pulse, so it is caught here
    always @(posedge clk) fab_seen <= fab_seen | fab;
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [31:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_run();
        n = 0;
        while (crst_n !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        chk("reset release", crst_n, 1);
    endtask
    task automatic pin_reset(int len);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (len) @(posedge clk);
        pin_n <= 1'b1;
    endtask
    task automatic wdog(logic en);
        @(posedge clk);
        wden <= en;
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("watchdog reset", crst_n, !en);
    endtask
    task automatic acc_chk(int b, logic ok);
        @(posedge clk);
        acc <= 1'b1;
        sel <= b[4:0];
        @(posedge clk);
        acc <= 1'b0;
        #1 chk("access valid", av, ok);
        chk("access refused", ar, !ok);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults();
        rreg(PCG_ADDR_GATE);
        chk("gate reset", v, PCG_GATE_RESET);
        rreg(PCG_ADDR_CAUSE);
        chk("cause reset", v, 1);
        rreg(32'h00000000);
        chk("unmapped read", v, 0);
        chk("boot address", boot, PCG_BOOT_ADDR);
        $display("defaults done");
    endtask
    task automatic t_gate();
        foreach (bits[i]) begin
            wreg(PCG_ADDR_GATE, 32'h1 << bits[i]);
            repeat (2) @(posedge clk);
            #1 chk("enables", pce, 32'h1 << bits[i]);
            acc_chk(bits[i], 1'b1);
        end
        wreg(PCG_ADDR_GATE, 32'hFFFFFFFF);
        rreg(PCG_ADDR_GATE);
        chk("reserved bits", v, PCG_GATE_USED);
        wreg(PCG_ADDR_GATE, 32'h0);
        acc_chk(PCG_BIT_CONVERT, 1'b0);
        chk("always on", aon, 1);
        $display("gate done");
    endtask
    task automatic t_div();
        logic [1:0] c[3] = '{PCG_DIV_FULL, PCG_DIV_HALF, PCG_DIV_QUARTER};
        for (int i = 0; i < 3; i++) begin
            wreg(PCG_ADDR_DIV, {30'h0, c[i]});
            wreg(PCG_ADDR_DIV, {30'h0, PCG_DIV_RSVD});
            rreg(PCG_ADDR_DIV);
            chk("divider code", v, c[i]);
            n = 0;
            repeat (16) begin
                @(posedge clk);
                #1 n += tick;
            end
            chk("tick count", n, 16 >> i);
        end
        wreg(PCG_ADDR_DIV, {30'h0, PCG_DIV_FULL});
        $display("divider done");
    endtask
    task automatic t_cause();
        pin_reset(10);
        repeat (4) @(posedge clk);
        #1 chk("short pulse", crst_n, 1);
        @(posedge clk);
        osc <= 1'b0;
        idle <= 1'b1;
        pll <= 1'b0;
        pin_reset(75);
        #1 chk("pin reset", crst_n, 0);
        repeat (60) @(posedge clk);
        osc <= 1'b1;
        #1 chk("oscillator wait", crst_n, 0);
        chk("pll kept", pkr, 1);
        wait_run();
        rreg(PCG_ADDR_GATE);
        chk("gate after reset", v, PCG_GATE_RESET);
        rreg(PCG_ADDR_DIV);
        chk("divider after reset", v, 0);
        rreg(PCG_ADDR_CAUSE);
        chk("pin cause", v, 3);
        wreg(PCG_ADDR_CAUSE, 0);
        wreg(PCG_ADDR_CAUSE, 1);
        cfgp <= 4'h5;
        rreg(PCG_ADDR_CAUSE);
        chk("clear one", v, 2);
        wdog(1'b0);
        wdog(1'b1);
        wait_run();
        rreg(PCG_ADDR_CAUSE);
        chk("watchdog cause", v, 6);
        chk("straps kept", cfg, 4'hA);
        @(posedge clk);
        fbusy <= 1'b1;
        fset <= 1'b0;
        pin_reset(75);
        repeat (40) @(posedge clk);
        fset <= 1'b1;
        #1 chk("flash hold", crst_n, 0);
        wait_run();
        chk("flash abort", fab_seen, 1);
        chk("straps taken", cfg, 4'h5);
        rreg(PCG_ADDR_CAUSE);
        chk("pin clears watchdog", v, 2);
        wreg(PCG_ADDR_CAUSE, 7);
        rreg(PCG_ADDR_CAUSE);
        chk("clear all", v, 0);
        $display("cause done");
    endtask
    task automatic results();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #200us;
        failures++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wait_run();
        t_defaults();
        t_gate();
        t_div();
        t_cause();
        results();
    end
endmodule
`default_nettype wire
